// file: core/fups_pkg.sv
// Purpose: Shared constants and carriers for the flash unlock sequencer
// Assumes: Byte-wide register port, one system clock
// Notes: Offsets are register indices on the byte register port
package fups_pkg;
   // Register offsets
   localparam logic [7:0] FUPS_CMD_ADDR = 8'h01;
   localparam logic [7:0] FUPS_PAGE_ADDR = 8'h02;
   localparam logic [7:0] FUPS_FREQ_HI_ADDR = 8'h03;
   localparam logic [7:0] FUPS_FREQ_LO_ADDR = 8'h04;
   // Command codes
   localparam logic [7:0] FUPS_CMD_UNLOCK1 = 8'h73;
   localparam logic [7:0] FUPS_CMD_UNLOCK2 = 8'h8c;
   localparam logic [7:0] FUPS_CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] FUPS_CMD_MASS_ERASE = 8'h63;
   localparam logic [7:0] FUPS_CMD_PROTECT = 8'h5e;
   // Readable state codes
   localparam logic [5:0] FUPS_ST_LOCKED = 6'h00;
   localparam logic [5:0] FUPS_ST_STEP1 = 6'h01;
   localparam logic [5:0] FUPS_ST_STEP2 = 6'h02;
   localparam logic [5:0] FUPS_ST_UNLOCKED = 6'h03;
   localparam logic [5:0] FUPS_ST_PROTSEL = 6'h04;
   localparam logic [5:0] FUPS_ST_PROGRAM = 6'h08;
   localparam logic [5:0] FUPS_ST_PERASE = 6'h10;
   localparam logic [5:0] FUPS_ST_MERASE = 6'h20;
   // Geometry
   localparam int FUPS_PAGE_BYTES = 512;
   localparam int FUPS_ROW_BYTES = 64;
   localparam int FUPS_ROWS_PER_PAGE = 8;
   localparam int FUPS_PAGES_PER_SECTOR = 16;
   localparam int FUPS_INFO_BYTES = 256;
   localparam logic [7:0] FUPS_INFO_USER_BASE = 8'hc0;
   localparam logic [7:0] FUPS_OPT0_ADDR = 8'hfe;
   localparam logic [7:0] FUPS_OPT1_ADDR = 8'hff;
   localparam logic [7:0] FUPS_PASS_CODE = 8'h5a;
   localparam logic [7:0] FUPS_ERASED = 8'hff;
   localparam int FUPS_PAGE_SEL_INFO_BIT = 7;
   // Reset values
   localparam logic [7:0] FUPS_PROTECT_RST = 8'h00;
   localparam logic [15:0] FUPS_FREQ_RST = 16'h0000;
   // Timing: cycles of the flash clock counted per frequency unit
   localparam int FUPS_PROG_UNITS = 1;
   localparam int FUPS_ERASE_UNITS = 4;

   typedef enum logic [2:0]
   {
      FUPS_LOCKED,
      FUPS_STEP1,
      FUPS_STEP2,
      FUPS_UNLOCKED,
      FUPS_PROTSEL,
      FUPS_PROGRAM,
      FUPS_PERASE,
      FUPS_MERASE
   } fups_state_t;

   // Register write request
   typedef struct packed
   {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
      logic fromSerial;
   } fups_reg_req_t;

   // Byte program request
   typedef struct packed
   {
      logic wr;
      logic info;
      logic [15:0] addr;
      logic [7:0] data;
   } fups_prog_req_t;
endpackage

// file: core/fups_sequencer.sv
// Purpose: Flash controller front end with unlock sequence and protection
// Assumes: Byte register writes and byte program requests, one clock
// Notes: Array is modelled in-block; timing count derived from frequency
//
// Functional notes
// - Main pages are 512 bytes, smallest erase
// - Page holds eight 64-byte rows
// - Sector is sixteen pages, 8 KB
// - Info block 256 bytes, only page 3 user
// - Info pages 0-2 unreachable externally
// - Option bytes at 00FE and 00FF
// - 00C0/00C1 hold test pass marker
// - All accesses are byte wide
// - Timing from 16-bit high/low frequency value
// - Reset enters locked state
// - Mismatched page reselect relocks; match activates
// - 95H erases page unless sector protected
// - Other command writes while unlocked relock
// - Active page accepts byte writes until command
// - After 5EH next 02H write hits protect
// - Protect resets zero; set bit blocks sector
// - Protect bits sticky until power down
// - Option byte 1 blocks external main reads
// - 63H mass erase only from serial port
// - Erase completion relocks controller
// - State encodes 000000..100000 as listed
// - Programming only clears bits
`timescale 1ns/1ns
module fups_sequencer
   import fups_pkg::*;
#(
   parameter int MAIN_PAGES = 128,
   parameter int ADDR_W = 16
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic clkEn,
   // Register port
   input wire fups_reg_req_t regReq,
   // Byte program port
   input wire fups_prog_req_t progReq,
   // Byte read port
   input wire logic rdReq,
   input wire logic rdInfo,
   input wire logic rdExternal,
   input wire logic [ADDR_W-1:0] rdAddr,
   // Status outputs
   output logic [7:0] statusByte,
   output logic [7:0] sectorProtect,
   output logic [15:0] timingValue,
   output logic busy,
   output logic [7:0] rdData,
   output logic rdValid
);
   localparam int MAIN_BYTES = MAIN_PAGES * FUPS_PAGE_BYTES;
   localparam int SECTORS = MAIN_PAGES / FUPS_PAGES_PER_SECTOR;

   // Array storage, byte wide
   logic [7:0] mainMem [MAIN_BYTES];
   logic [7:0] infoMem [FUPS_INFO_BYTES];

   // All control state in one record
   typedef struct packed
   {
      fups_state_t st;
      logic [7:0] page;
      logic [7:0] protect;
      logic [15:0] freq;
      logic [23:0] cnt;
      logic [7:0] status;
      logic busy;
      logic [7:0] rdData;
      logic rdValid;
   } fups_regs_t;

   fups_regs_t cur_ff;
   fups_regs_t nxt_cur;

   // Decoded helpers
   logic pageInfo;
   logic [6:0] pageNum;
   logic sectorLocked;
   logic progHit;
   logic progOk;
   logic [7:0] opt1;
   logic readBlocked;

   assign pageInfo = cur_ff.page[FUPS_PAGE_SEL_INFO_BIT];
   assign pageNum = cur_ff.page[6:0];

   // Sector of the active page, blocked by its protect bit
   always_comb
   begin
      sectorLocked = 1'b0;
      if (int'(pageNum) / FUPS_PAGES_PER_SECTOR < SECTORS)
      begin
         sectorLocked = cur_ff.protect[pageNum[6:4]];
      end
   end

   // Program target must lie in the active page; info only page 3
   always_comb
   begin
      if (progReq.info)
      begin
         progHit = pageInfo && progReq.addr[7:6] == 2'b11;
      end
      else
      begin
         progHit = !pageInfo && progReq.addr[15:9] == pageNum;
      end
   end
   assign progOk = progReq.wr && cur_ff.st == FUPS_UNLOCKED && progHit
      && (progReq.info || !sectorLocked);

   // Option byte 1 drives external read blocking (bit 7 low = protect)
   assign opt1 = infoMem[FUPS_OPT1_ADDR];
   assign readBlocked = rdExternal && !rdInfo && !opt1[7];

   // Next-state logic for the sequencer
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.rdValid = 1'b0;
      // Erase or program timing runs down from the derived count
      if (cur_ff.st == FUPS_PROGRAM || cur_ff.st == FUPS_PERASE
         || cur_ff.st == FUPS_MERASE)
      begin
         if (cur_ff.cnt != 24'h000000)
         begin
            nxt_cur.cnt = cur_ff.cnt - 24'h000001;
         end
         else if (cur_ff.st == FUPS_PROGRAM)
         begin
            nxt_cur.st = FUPS_UNLOCKED;
         end
         else
         begin
            nxt_cur.st = FUPS_LOCKED;
         end
      end
      else if (regReq.wr)
      begin
         case (regReq.addr)
            FUPS_CMD_ADDR:
            begin
               case (cur_ff.st)
                  FUPS_LOCKED:
                     nxt_cur.st = regReq.data == FUPS_CMD_UNLOCK1
                        ? FUPS_STEP1 : FUPS_LOCKED;
                  FUPS_STEP1:
                     nxt_cur.st = regReq.data == FUPS_CMD_UNLOCK2
                        ? FUPS_STEP2 : FUPS_LOCKED;
                  FUPS_UNLOCKED:
                  begin
                     nxt_cur.st = FUPS_LOCKED;
                     if (regReq.data == FUPS_CMD_PAGE_ERASE
                        && (pageInfo || !sectorLocked)
                        && (!pageInfo || pageNum == 7'h03))
                     begin
                        nxt_cur.st = FUPS_PERASE;
                        nxt_cur.cnt = 24'(cur_ff.freq)
                           * 24'(FUPS_ERASE_UNITS);
                     end
                     else if (regReq.data == FUPS_CMD_MASS_ERASE
                        && regReq.fromSerial)
                     begin
                        nxt_cur.st = FUPS_MERASE;
                        nxt_cur.cnt = 24'(cur_ff.freq)
                           * 24'(FUPS_ERASE_UNITS);
                     end
                     else if (regReq.data == FUPS_CMD_PROTECT)
                     begin
                        nxt_cur.st = FUPS_PROTSEL;
                     end
                  end
                  default:
                     nxt_cur.st = FUPS_LOCKED;
               endcase
            end
            FUPS_PAGE_ADDR:
            begin
               if (cur_ff.st == FUPS_PROTSEL)
               begin
                  // Sticky: only sets, never clears
                  nxt_cur.protect = cur_ff.protect | regReq.data;
                  nxt_cur.st = FUPS_LOCKED;
               end
               else if (cur_ff.st == FUPS_STEP2)
               begin
                  nxt_cur.st = regReq.data == cur_ff.page
                     ? FUPS_UNLOCKED : FUPS_LOCKED;
               end
               else
               begin
                  nxt_cur.page = regReq.data;
                  if (cur_ff.st != FUPS_LOCKED)
                  begin
                     nxt_cur.st = FUPS_LOCKED;
                  end
               end
            end
            FUPS_FREQ_HI_ADDR:
               nxt_cur.freq = {regReq.data, cur_ff.freq[7:0]};
            FUPS_FREQ_LO_ADDR:
               nxt_cur.freq = {cur_ff.freq[15:8], regReq.data};
            default:
               nxt_cur.freq = cur_ff.freq;
         endcase
      end
      else if (progOk)
      begin
         nxt_cur.st = FUPS_PROGRAM;
         nxt_cur.cnt = 24'(cur_ff.freq) * 24'(FUPS_PROG_UNITS);
      end
      // Byte read, blocked externally or outside user info page
      if (rdReq)
      begin
         nxt_cur.rdValid = 1'b1;
         if (readBlocked || (rdInfo && rdAddr[7:6] != 2'b11))
         begin
            nxt_cur.rdData = 8'h00;
         end
         else if (rdInfo && rdAddr[7:1] == 7'h60)
         begin
            // Pass marker is fixed, so an info erase cannot lose it
            nxt_cur.rdData = FUPS_PASS_CODE;
         end
         else if (rdInfo)
         begin
            nxt_cur.rdData = infoMem[rdAddr[7:0]];
         end
         else
         begin
            nxt_cur.rdData = mainMem[rdAddr[$clog2(MAIN_BYTES)-1:0]];
         end
      end
      // Readable state field
      case (nxt_cur.st)
         FUPS_LOCKED: nxt_cur.status = {2'b00, FUPS_ST_LOCKED};
         FUPS_STEP1: nxt_cur.status = {2'b00, FUPS_ST_STEP1};
         FUPS_STEP2: nxt_cur.status = {2'b00, FUPS_ST_STEP2};
         FUPS_UNLOCKED: nxt_cur.status = {2'b00, FUPS_ST_UNLOCKED};
         FUPS_PROTSEL: nxt_cur.status = {2'b00, FUPS_ST_PROTSEL};
         FUPS_PROGRAM: nxt_cur.status = {2'b00, FUPS_ST_PROGRAM};
         FUPS_PERASE: nxt_cur.status = {2'b00, FUPS_ST_PERASE};
         FUPS_MERASE: nxt_cur.status = {2'b00, FUPS_ST_MERASE};
         default: nxt_cur.status = 8'h00;
      endcase
      nxt_cur.busy = nxt_cur.st == FUPS_PROGRAM
         || nxt_cur.st == FUPS_PERASE || nxt_cur.st == FUPS_MERASE;
   end

   // State register; reset locks the controller
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cur_ff <= '0;
         cur_ff.st <= FUPS_LOCKED;
         cur_ff.protect <= FUPS_PROTECT_RST;
         cur_ff.freq <= FUPS_FREQ_RST;
      end
      else if (clkEn)
      begin
         cur_ff <= nxt_cur;
      end
   end

   // Array updates: program ANDs, erase fills with ones
   always_ff @(posedge clk)
   begin
      if (clkEn)
      begin
         if (progOk && !regReq.wr && !busy)
         begin
            if (progReq.info)
            begin
               infoMem[progReq.addr[7:0]] <=
                  infoMem[progReq.addr[7:0]] & progReq.data;
            end
            else
            begin
               mainMem[progReq.addr[$clog2(MAIN_BYTES)-1:0]] <=
                  mainMem[progReq.addr[$clog2(MAIN_BYTES)-1:0]]
                  & progReq.data;
            end
         end
         if (cur_ff.st == FUPS_PERASE && cur_ff.cnt == 24'h000000)
         begin
            if (pageInfo)
            begin
               for (int i = 0; i < FUPS_ROW_BYTES; i++)
               begin
                  infoMem[int'(FUPS_INFO_USER_BASE) + i] <= FUPS_ERASED;
               end
            end
            else
            begin
               for (int i = 0; i < FUPS_PAGE_BYTES; i++)
               begin
                  mainMem[int'(pageNum) * FUPS_PAGE_BYTES + i]
                     <= FUPS_ERASED;
               end
            end
         end
         if (cur_ff.st == FUPS_MERASE && cur_ff.cnt == 24'h000000)
         begin
            for (int i = 0; i < MAIN_BYTES; i++)
            begin
               mainMem[i] <= FUPS_ERASED;
            end
         end
      end
   end

   // Outputs straight from flops
   assign statusByte = cur_ff.status;
   assign sectorProtect = cur_ff.protect;
   assign timingValue = cur_ff.freq;
   assign busy = cur_ff.busy;
   assign rdData = cur_ff.rdData;
   assign rdValid = cur_ff.rdValid;

   // Unlock only after the matching page rewrite
   unlock_seq_a: assert property (
      @(posedge clk) disable iff (!nrst)
      clkEn && cur_ff.st == FUPS_STEP2 && regReq.wr
      && regReq.addr == FUPS_PAGE_ADDR && regReq.data != cur_ff.page
      |=> statusByte == 8'h00)
      else $error("mismatched page did not relock");
   // No protect bit ever falls back to zero
   protect_sticky_a: assert property (
      @(posedge clk) disable iff (!nrst)
      ($past(sectorProtect) & ~sectorProtect) == 8'h00)
      else $error("protect bit cleared");
   // Any command but erase or protect relocks
   bad_cmd_a: assert property (
      @(posedge clk) disable iff (!nrst)
      clkEn && cur_ff.st == FUPS_UNLOCKED && regReq.wr
      && regReq.addr == FUPS_CMD_ADDR && regReq.data != FUPS_CMD_PAGE_ERASE
      && regReq.data != FUPS_CMD_MASS_ERASE
      && regReq.data != FUPS_CMD_PROTECT
      |=> statusByte == 8'h00)
      else $error("bad command kept unlock");
   // Processor side never starts a mass erase
   mass_cpu_a: assert property (
      @(posedge clk) disable iff (!nrst)
      clkEn && !busy && regReq.wr && !regReq.fromSerial
      && regReq.addr == FUPS_CMD_ADDR |=> cur_ff.st != FUPS_MERASE)
      else $error("mass erase from cpu");
   // Page erase end drops back to locked
   erase_end_a: assert property (
      @(posedge clk) disable iff (!nrst)
      clkEn && cur_ff.st == FUPS_PERASE && cur_ff.cnt == 24'h000000
      |=> statusByte == 8'h00)
      else $error("erase end did not lock");
   // Byte program end keeps the page unlocked
   prog_done_a: assert property (
      @(posedge clk) disable iff (!nrst)
      clkEn && cur_ff.st == FUPS_PROGRAM && cur_ff.cnt == 24'h000000
      |=> statusByte == {2'b00, FUPS_ST_UNLOCKED})
      else $error("program end lost the page");
   unlock_cov_c: cover property (@(posedge clk) cur_ff.st == FUPS_UNLOCKED);
   erase_cov_c: cover property (@(posedge clk) cur_ff.st == FUPS_PERASE);
   prot_cov_c: cover property (@(posedge clk) cur_ff.st == FUPS_PROTSEL);
endmodule

// file: testbench/fups_host_model.sv
// Purpose: Host-side partner issuing register, program and read requests
// Assumes: Requests launch at the falling edge and are taken at the rising
// Notes: Waits for busy to clear first, so no request is dropped silently
`timescale 1ns/1ns
module fups_host_model
   import fups_pkg::*;
(
   // Clock and answers from the sequencer
   input wire logic clk,
   input wire logic busy,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   // Requests toward the sequencer
   output fups_reg_req_t regReq,
   output fups_prog_req_t progReq,
   output logic rdReq,
   output logic rdInfo,
   output logic rdExternal,
   output logic [15:0] rdAddr
);
   // Quiet bus at time zero
   initial
   begin
      regReq = '0;
      progReq = '0;
      rdReq = 1'b0;
      rdInfo = 1'b0;
      rdExternal = 1'b0;
      rdAddr = 16'h0000;
   end

   // Timing figure is twice the clock in kHz; the bench scales the clock
   // down to a nominal 3 kHz, far below its 25 MHz, to keep erases short
   function automatic logic [15:0] freqFor(input int khz);
      return 16'(2 * khz);
   endfunction

   // Holds off while a program or erase runs; bounded against a hang
   task automatic waitIdle();
      int n;
      n = 0;
      @(negedge clk);
      while (busy !== 1'b0 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   // One register write, a single-cycle strobe
   task automatic regWrite(input logic [7:0] a, input logic [7:0] d,
      input logic serial);
      waitIdle();
      regReq = '{wr: 1'b1, addr: a, data: d, fromSerial: serial};
      @(negedge clk);
      regReq.wr = 1'b0;
      // Released lines do not keep their last value
      regReq.data = ~d;
      regReq.addr = ~a;
   endtask

   // One byte program request, eight bits at a time
   task automatic progByte(input logic info, input logic [15:0] a,
      input logic [7:0] d);
      waitIdle();
      progReq = '{wr: 1'b1, info: info, addr: a, data: d};
      @(negedge clk);
      progReq.wr = 1'b0;
      progReq.data = ~d;
   endtask

   // One byte read; address held until the answer is seen
   task automatic readByte(input logic info, input logic ext,
      input logic [15:0] a, output logic [7:0] d);
      int n;
      waitIdle();
      rdReq = 1'b1;
      rdInfo = info;
      rdExternal = ext;
      rdAddr = a;
      @(negedge clk);
      rdReq = 1'b0;
      n = 0;
      while (rdValid !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      d = (rdValid === 1'b1) ? rdData : 8'hxx;
      rdAddr = ~a;
   endtask
endmodule

// file: testbench/tb.sv
// Purpose: Self-checking bench for the flash unlock sequencer
// Assumes: Host model drives all requests at the falling edge
// Notes: Timing figure kept small so erases last tens of cycles
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin compares++; if ((got) !== (exp)) begin failCount++; \
   $display("unexpected at %0t line %0d: got %h exp %h", $time, \
   `__LINE__, got, exp); end end
module tb;
   import fups_pkg::*;
   localparam logic [7:0] PA = 8'd20; // Main page in sector 1
   localparam logic [7:0] INFO3 = 8'h83; // Info page 3 select
   localparam int LIMIT = 20000;
   logic clk, nrst, clkEn, rdReq, rdInfo, rdExternal, busy, rdValid;
   fups_reg_req_t regReq;
   fups_prog_req_t progReq;
   logic [15:0] rdAddr, timingValue, a;
   logic [7:0] statusByte, sectorProtect, rdData, lfsr, d, d2;
   int failCount, compares, cycles;

   fups_sequencer fups_sequencer_i (.clk(clk), .nrst(nrst), .clkEn(clkEn),
      .regReq(regReq), .progReq(progReq), .rdReq(rdReq), .rdInfo(rdInfo),
      .rdExternal(rdExternal), .rdAddr(rdAddr), .statusByte(statusByte),
      .sectorProtect(sectorProtect), .timingValue(timingValue),
      .busy(busy), .rdData(rdData), .rdValid(rdValid));
   fups_host_model fups_host_model_i (.clk(clk), .busy(busy),
      .rdData(rdData), .rdValid(rdValid), .regReq(regReq),
      .progReq(progReq), .rdReq(rdReq), .rdInfo(rdInfo),
      .rdExternal(rdExternal), .rdAddr(rdAddr));

   // Byte address of a main page, and its sector's protect bit
   function automatic logic [15:0] pageBase(input logic [7:0] p);
      return {p[6:0], 9'h000};
   endfunction
   function automatic logic [7:0] sectorBit(input logic [7:0] p);
      return 8'h01 << p[6:4];
   endfunction
   // Eight-bit shift register for repeatable random bytes
   function automatic logic [7:0] lfsrNext(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Verdict and end of run, reached from the main sequence or the hang limit
   task automatic summarize();
      $display("compares %0d failCount %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         failCount++;
         summarize();
      end
   end

   // Full unlock walk, status watched after each unlock command and the page rewrite
   task automatic unlock(input logic [7:0] p);
      fups_host_model_i.regWrite(FUPS_PAGE_ADDR, p, 1'b0);
      fups_host_model_i.regWrite(FUPS_CMD_ADDR, FUPS_CMD_UNLOCK1, 1'b0);
      `CHK(statusByte, {2'b00, FUPS_ST_STEP1})
      fups_host_model_i.regWrite(FUPS_CMD_ADDR, FUPS_CMD_UNLOCK2, 1'b0);
      `CHK(statusByte, {2'b00, FUPS_ST_STEP2})
      fups_host_model_i.regWrite(FUPS_PAGE_ADDR, p, 1'b0);
      `CHK(statusByte, {2'b00, FUPS_ST_UNLOCKED})
   endtask

   task automatic cmd(input logic [7:0] c, input logic serial);
      fups_host_model_i.regWrite(FUPS_CMD_ADDR, c, serial);
   endtask

   task automatic checkRead(input logic info, input logic ext,
      input logic [15:0] ad, input logic [7:0] exp);
      logic [7:0] got;
      fups_host_model_i.readByte(info, ext, ad, got);
      `CHK(got, exp)
   endtask

   // Main sequence
   initial
   begin
      failCount = 0;
      compares = 0;
      cycles = 0;
      lfsr = 8'h09;
      clkEn = 1'b1;
      nrst = 1'b0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      `CHK(statusByte, 8'h00)
      `CHK(sectorProtect, FUPS_PROTECT_RST)
      // Frozen clock enable: a command strobe leaves the state alone
      clkEn = 1'b0;
      cmd(FUPS_CMD_UNLOCK1, 1'b0);
      `CHK(statusByte, 8'h00)
      clkEn = 1'b1;
      // Timing value from two byte registers
      fups_host_model_i.regWrite(FUPS_FREQ_HI_ADDR, 8'h00, 1'b0);
      fups_host_model_i.regWrite(FUPS_FREQ_LO_ADDR,
         8'(fups_host_model_i.freqFor(3)), 1'b0);
      `CHK(timingValue, fups_host_model_i.freqFor(3))
      // Mass erase from the serial port clears the array
      unlock(PA);
      cmd(FUPS_CMD_MASS_ERASE, 1'b1);
      `CHK(statusByte, {2'b00, FUPS_ST_MERASE})
      fups_host_model_i.waitIdle();
      `CHK(statusByte, 8'h00)
      checkRead(1'b0, 1'b0, pageBase(PA) + 16'h0077, FUPS_ERASED);
      // Random bytes on the active page; second write only clears bits
      unlock(PA);
      for (int i = 0; i < 4; i++)
      begin
         lfsr = lfsrNext(lfsr);
         a = pageBase(PA) + {7'h00, i[1:0], lfsr[6:0]};
         lfsr = lfsrNext(lfsr);
         d = lfsr;
         lfsr = lfsrNext(lfsr);
         d2 = lfsr;
         fups_host_model_i.progByte(1'b0, a, d);
         `CHK(statusByte, {2'b00, FUPS_ST_PROGRAM})
         fups_host_model_i.waitIdle();
         `CHK(statusByte, {2'b00, FUPS_ST_UNLOCKED})
         fups_host_model_i.progByte(1'b0, a, d2);
         checkRead(1'b0, 1'b0, a, d & d2);
      end
      // Last byte of the page taken, first byte of the next ignored
      fups_host_model_i.progByte(1'b0, pageBase(PA) + 16'h01ff, 8'h3c);
      checkRead(1'b0, 1'b0, pageBase(PA) + 16'h01ff, 8'h3c);
      fups_host_model_i.progByte(1'b0, pageBase(PA + 8'd1), 8'h00);
      checkRead(1'b0, 1'b0, pageBase(PA + 8'd1), FUPS_ERASED);
      // Unknown command relocks; later programs are ignored
      cmd(8'h42, 1'b0);
      `CHK(statusByte, 8'h00)
      fups_host_model_i.progByte(1'b0, pageBase(PA) + 16'h0005, 8'h00);
      checkRead(1'b0, 1'b0, pageBase(PA) + 16'h0005, FUPS_ERASED);
      // Mismatched reselect of the page relocks
      fups_host_model_i.regWrite(FUPS_PAGE_ADDR, PA, 1'b0);
      cmd(FUPS_CMD_UNLOCK1, 1'b0);
      cmd(FUPS_CMD_UNLOCK2, 1'b0);
      fups_host_model_i.regWrite(FUPS_PAGE_ADDR, PA + 8'd1, 1'b0);
      `CHK(statusByte, 8'h00)
      // Page erase, then automatic relock
      unlock(PA);
      cmd(FUPS_CMD_PAGE_ERASE, 1'b0);
      `CHK(statusByte, {2'b00, FUPS_ST_PERASE})
      `CHK(busy, 1'b1)
      fups_host_model_i.waitIdle();
      `CHK(statusByte, 8'h00)
      checkRead(1'b0, 1'b0, pageBase(PA) + 16'h01ff, FUPS_ERASED);
      // Mass erase refused from the processor side
      unlock(PA);
      fups_host_model_i.progByte(1'b0, pageBase(PA), 8'h00);
      cmd(FUPS_CMD_MASS_ERASE, 1'b0);
      fups_host_model_i.waitIdle();
      checkRead(1'b0, 1'b0, pageBase(PA), 8'h00);
      // Protect the sector, then try to clear the bit
      for (int k = 0; k < 2; k++)
      begin
         unlock(PA);
         cmd(FUPS_CMD_PROTECT, 1'b0);
         `CHK(statusByte, {2'b00, FUPS_ST_PROTSEL})
         fups_host_model_i.regWrite(FUPS_PAGE_ADDR,
            (k == 0) ? sectorBit(PA) : 8'h00, 1'b0);
         `CHK(sectorProtect, sectorBit(PA))
      end
      // Protected sector refuses erase and program
      unlock(PA);
      cmd(FUPS_CMD_PAGE_ERASE, 1'b0);
      fups_host_model_i.waitIdle();
      checkRead(1'b0, 1'b0, pageBase(PA), 8'h00);
      unlock(PA);
      fups_host_model_i.progByte(1'b0, pageBase(PA) + 16'h0001, 8'h00);
      checkRead(1'b0, 1'b0, pageBase(PA) + 16'h0001, FUPS_ERASED);
      // Info page 3: erase, lock external reads by option byte 1
      unlock(INFO3);
      cmd(FUPS_CMD_PAGE_ERASE, 1'b0);
      fups_host_model_i.waitIdle();
      unlock(INFO3);
      fups_host_model_i.progByte(1'b1, {8'h00, FUPS_OPT1_ADDR}, 8'h7f);
      checkRead(1'b1, 1'b0, {8'h00, FUPS_OPT1_ADDR}, 8'h7f);
      checkRead(1'b0, 1'b1, pageBase(PA) + 16'h0002, 8'h00);
      checkRead(1'b0, 1'b0, pageBase(PA) + 16'h0002, FUPS_ERASED);
      unlock(INFO3);
      cmd(FUPS_CMD_PAGE_ERASE, 1'b0);
      fups_host_model_i.waitIdle();
      checkRead(1'b1, 1'b0, {8'h00, FUPS_OPT1_ADDR}, FUPS_ERASED);
      checkRead(1'b0, 1'b1, pageBase(PA) + 16'h0002, FUPS_ERASED);
      checkRead(1'b1, 1'b0, 16'h00c0, FUPS_PASS_CODE);
      checkRead(1'b1, 1'b0, 16'h0010, 8'h00);
      summarize();
   end
endmodule
